// ==== logic/cgp_pin_ctrl.sv ====
// Second multipurpose pin function logic and bus-pin (SDA/SCL) general I/O.
// Registers are reached through the device's internal 8-bit register port,
// which the control-bus slave drives; interrupt sources arrive from the
// detection logic on clk; pins arrive asynchronously and are synchronised.
`timescale 1ns/1ps
// Contract
// - Bits 7:4 pick pin function: 0000 off, 0011 input, 0100 output, 0001 reserved.
// - Code 0010 drives active-high jack detect interrupt, about 1.75 ms.
// - Codes 0101-0111 take microphone data, sampled on both clock edges.
// - Code 1000 uses the pin as bit clock, direction set elsewhere.
// - Code 1001 outputs headset OR button interrupt.
// - Code 1010 outputs headset, button, short-circuit, gain-noise OR.
// - Code 1011 outputs short-circuit OR noise; 1100 and 1110 short-circuit only.
// - Code 1111 outputs button or hookswitch interrupt.
// - Bit 3 sets the general output level.
// - Read-only bit 2 shows the pin level in general input mode.
// - Bit 1 clear gives one 2 ms pulse (1.75 ms for code 0010); set repeats until flags read.
// - SDA mode bits 7:6: 00 off, 01 input, 10 output; 11 never written.
// - SDA output: bit 5 low pulls down, high releases the pin.
// - Bit 4 shows sampled SDA level in input mode.
// - SCL mode bits 3:2: 00 off, 01 input, 10 output; 11 never written.
// - SCL output: bit 1 low pulls down, high releases the pin.
// - Bit 0 shows sampled SCL level in input mode.
// - SDA and SCL are only ever pulled low, never driven high.
// - SDA/SCL general controls act only when the SPI interface is selected.
module cgp_pin_ctrl
    import cgp_pkg::*;
#(
    parameter int PULSE_CYC = CGP_PULSE_CYC,
    parameter int JACK_PULSE_CYC = CGP_JACK_PULSE_CYC,
    parameter int CNT_W = 18
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    // Interrupt sources and flags-read strobe
    input wire logic irq_headset,
    input wire logic irq_button,
    input wire logic irq_short,
    input wire logic irq_agc_noise,
    input wire logic flags_read,
    // Control-bus select strap level, high for SPI
    input wire logic spi_select,
    // Second multipurpose pin
    input wire logic pin2_i,
    output logic pin2_o,
    output logic pin2_oe,
    // Bit clock use of the pin
    input wire logic bclk_out,
    input wire logic bclk_master,
    output logic bclk_in,
    // Digital microphone
    input wire logic dmic_clk,
    output logic dmic_rise_data,
    output logic dmic_fall_data,
    output logic dmic_en,
    // Bus pins, open drain
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe
);
    logic [7:0] ctrl_q;
    logic [7:0] bus_q;
    logic pin2_sync;
    logic sda_sync;
    logic scl_sync;
    logic spi_sync;
    logic dclk_sync;
    logic dclk_prev_q;
    logic rise_q;
    logic fall_q;
    logic src_q;
    logic irq_pulse;
    logic [7:0] rdata_q;

    // Synchronisers for every asynchronous pin
    cgp_sync3 u_sync_pin2 (.clk(clk), .rst_n(rst_n), .din(pin2_i), .dout(pin2_sync));
    cgp_sync3 u_sync_sda (.clk(clk), .rst_n(rst_n), .din(sda_i), .dout(sda_sync));
    cgp_sync3 u_sync_scl (.clk(clk), .rst_n(rst_n), .din(scl_i), .dout(scl_sync));
    cgp_sync3 u_sync_sel (.clk(clk), .rst_n(rst_n), .din(spi_select), .dout(spi_sync));
    cgp_sync3 u_sync_dclk (.clk(clk), .rst_n(rst_n), .din(dmic_clk), .dout(dclk_sync));

    // Field decode
    wire [3:0] fn = ctrl_q[CGP_FN_HI:CGP_FN_LO];
    wire out_val = ctrl_q[CGP_OUT_BIT];
    wire repeat_en = ctrl_q[CGP_REP_BIT];
    wire [1:0] sda_mode = bus_q[CGP_SDA_MODE_HI:CGP_SDA_MODE_LO];
    wire [1:0] scl_mode = bus_q[CGP_SCL_MODE_HI:CGP_SCL_MODE_LO];

    wire fn_gp_in = (fn == CGP_FN_GP_IN);
    wire fn_gp_out = (fn == CGP_FN_GP_OUT);
    wire fn_dmic = (fn == CGP_FN_DMIC_A) || (fn == CGP_FN_DMIC_B)
        || (fn == CGP_FN_DMIC_C);
    wire fn_bclk = (fn == CGP_FN_BCLK);
    wire fn_jack = (fn == CGP_FN_JACK_IRQ);

    // Interrupt source selection by function code
    logic src_sel;
    logic fn_irq;
    always_comb begin
        src_sel = 1'b0;
        fn_irq = 1'b1;
        case (fn)
            CGP_FN_JACK_IRQ: src_sel = irq_headset;
            CGP_FN_HS_BTN: src_sel = irq_headset | irq_button;
            CGP_FN_ALL4: begin
                src_sel = irq_headset | irq_button | irq_short | irq_agc_noise;
            end
            CGP_FN_SC_AGC: src_sel = irq_short | irq_agc_noise;
            CGP_FN_SC_A, CGP_FN_SC_B: src_sel = irq_short;
            CGP_FN_BTN: src_sel = irq_button;
            CGP_FN_UNDEF: fn_irq = 1'b0;
            default: fn_irq = 1'b0;
        endcase
    end

    // Start a pulse on each new assertion of the selected source while the pulse generator is idle
    wire trig = src_sel && !src_q;
    wire [CNT_W-1:0] len = fn_jack ? CNT_W'(JACK_PULSE_CYC - 1)
        : CNT_W'(PULSE_CYC - 1);

    cgp_pulse_gen #(.CNT_W(CNT_W)) u_pulse (
        .clk(clk),
        .rst_n(rst_n),
        .trig(trig),
        .repeat_en(repeat_en),
        .flags_read(flags_read),
        .len(len),
        .pulse(irq_pulse)
    );

    // Microphone data: capture the pin on each clock edge seen in clk domain.
    // Edge detect uses the settled synchroniser output only.
    wire dclk_rise = dclk_sync && !dclk_prev_q;
    wire dclk_fall = !dclk_sync && dclk_prev_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            src_q <= 1'b0;
            dclk_prev_q <= 1'b0;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            src_q <= src_sel & fn_irq;
            dclk_prev_q <= dclk_sync;
            if (fn_dmic && dclk_rise) begin
                rise_q <= pin2_sync;
            end
            if (fn_dmic && dclk_fall) begin
                fall_q <= pin2_sync;
            end
        end
    end

    assign dmic_rise_data = rise_q;
    assign dmic_fall_data = fall_q;
    assign dmic_en = fn_dmic;
    assign bclk_in = fn_bclk ? pin2_sync : 1'b0;

    // Pin drive: output level, interrupt pulse, or bit clock when master
    assign pin2_oe = fn_gp_out || (fn_irq && !fn_dmic) || (fn_bclk && bclk_master);
    assign pin2_o = fn_gp_out ? out_val
        : fn_bclk ? bclk_out
        : (fn_irq & irq_pulse);

    // Bus pins: pull-down only, gated by the SPI selection
    wire sda_gp_out = spi_sync && (sda_mode == CGP_BUS_OUT);
    wire scl_gp_out = spi_sync && (scl_mode == CGP_BUS_OUT);
    wire sda_gp_in = spi_sync && (sda_mode == CGP_BUS_IN);
    wire scl_gp_in = spi_sync && (scl_mode == CGP_BUS_IN);
    assign sda_o = 1'b0;
    assign scl_o = 1'b0;
    assign sda_oe = sda_gp_out && !bus_q[CGP_SDA_OUT_BIT];
    assign scl_oe = scl_gp_out && !bus_q[CGP_SCL_OUT_BIT];

    // Register writes store all eight bits; read-only positions are replaced on read
    wire wr_ctrl = reg_wr && (reg_addr == CGP_OFF_PIN2_CTRL);
    wire wr_bus = reg_wr && (reg_addr == CGP_OFF_BUS_GPIO);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q <= CGP_RESET_VAL;
            bus_q <= CGP_RESET_VAL;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= reg_wdata;
            end
            if (wr_bus) begin
                bus_q <= reg_wdata;
            end
        end
    end

    // Read view: live input bits replace stored read-only positions
    logic [7:0] ctrl_view;
    logic [7:0] bus_view;
    always_comb begin
        ctrl_view = ctrl_q;
        ctrl_view[CGP_IN_BIT] = fn_gp_in & pin2_sync;
        ctrl_view[CGP_RSV_BIT] = 1'b0;
        bus_view = bus_q;
        bus_view[CGP_SDA_IN_BIT] = sda_gp_in & sda_sync;
        bus_view[CGP_SCL_IN_BIT] = scl_gp_in & scl_sync;
    end

    wire hit = (reg_addr == CGP_OFF_PIN2_CTRL) || (reg_addr == CGP_OFF_BUS_GPIO);
    wire [7:0] rd_sel = (reg_addr == CGP_OFF_PIN2_CTRL) ? ctrl_view
        : (reg_addr == CGP_OFF_BUS_GPIO) ? bus_view : 8'h00;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            rdata_q <= rd_sel;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_hit = hit;
endmodule : cgp_pin_ctrl

// ==== logic/cgp_pkg.sv ====
// Constants for the second multipurpose pin and bus-pin general I/O block.
// Assumes a 100 MHz core clock; register port is the device's internal 8-bit map.
package cgp_pkg;
    localparam logic [6:0] CGP_OFF_PIN2_CTRL = 7'h63;
    localparam logic [6:0] CGP_OFF_BUS_GPIO = 7'h64;
    localparam logic [7:0] CGP_RESET_VAL = 8'h00;

    // Field positions
    localparam int CGP_FN_HI = 7;
    localparam int CGP_FN_LO = 4;
    localparam int CGP_OUT_BIT = 3;
    localparam int CGP_IN_BIT = 2;
    localparam int CGP_REP_BIT = 1;
    localparam int CGP_RSV_BIT = 0;
    localparam int CGP_SDA_MODE_HI = 7;
    localparam int CGP_SDA_MODE_LO = 6;
    localparam int CGP_SDA_OUT_BIT = 5;
    localparam int CGP_SDA_IN_BIT = 4;
    localparam int CGP_SCL_MODE_HI = 3;
    localparam int CGP_SCL_MODE_LO = 2;
    localparam int CGP_SCL_OUT_BIT = 1;
    localparam int CGP_SCL_IN_BIT = 0;

    // Function codes of the second pin
    localparam logic [3:0] CGP_FN_DISABLED = 4'h0;
    localparam logic [3:0] CGP_FN_RESERVED = 4'h1;
    localparam logic [3:0] CGP_FN_JACK_IRQ = 4'h2;
    localparam logic [3:0] CGP_FN_GP_IN = 4'h3;
    localparam logic [3:0] CGP_FN_GP_OUT = 4'h4;
    localparam logic [3:0] CGP_FN_DMIC_A = 4'h5;
    localparam logic [3:0] CGP_FN_DMIC_B = 4'h6;
    localparam logic [3:0] CGP_FN_DMIC_C = 4'h7;
    localparam logic [3:0] CGP_FN_BCLK = 4'h8;
    localparam logic [3:0] CGP_FN_HS_BTN = 4'h9;
    localparam logic [3:0] CGP_FN_ALL4 = 4'ha;
    localparam logic [3:0] CGP_FN_SC_AGC = 4'hb;
    localparam logic [3:0] CGP_FN_SC_A = 4'hc;
    localparam logic [3:0] CGP_FN_UNDEF = 4'hd;
    localparam logic [3:0] CGP_FN_SC_B = 4'he;
    localparam logic [3:0] CGP_FN_BTN = 4'hf;

    // Bus-pin modes
    localparam logic [1:0] CGP_BUS_OFF = 2'b00;
    localparam logic [1:0] CGP_BUS_IN = 2'b01;
    localparam logic [1:0] CGP_BUS_OUT = 2'b10;

    // Pulse timing
    localparam int CGP_CLK_HZ = 100_000_000;
    localparam int CGP_PULSE_US = 2000;
    localparam int CGP_JACK_PULSE_US = 1750;
    localparam int CGP_PULSE_CYC = CGP_PULSE_US * (CGP_CLK_HZ / 1_000_000);
    localparam int CGP_JACK_PULSE_CYC = CGP_JACK_PULSE_US * (CGP_CLK_HZ / 1_000_000);

    typedef enum logic [2:0] {
        CGP_ST_IDLE = 3'b001,
        CGP_ST_HIGH = 3'b010,
        CGP_ST_LOW = 3'b100
    } cgp_pulse_st_t;
endpackage : cgp_pkg

// ==== logic/cgp_pulse_gen.sv ====
// Interrupt pulse shaper for the second pin.
// A rising source starts one high pulse; in repeat mode high and low phases
// alternate until the host reads the interrupt flags register.
`timescale 1ns/1ps
module cgp_pulse_gen
    import cgp_pkg::*;
#(
    parameter int CNT_W = 18
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic trig,
    input wire logic repeat_en,
    input wire logic flags_read,
    input wire logic [CNT_W-1:0] len,
    // Output
    output logic pulse
);
    cgp_pulse_st_t st_q;
    cgp_pulse_st_t st_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic out_q;
    // Stop request is sticky; a new trigger in the same cycle wins over it
    logic stop_q;
    wire last = (cnt_q == '0);

    always_comb begin
        st_d = st_q;
        cnt_d = last ? cnt_q : cnt_q - 1'b1;
        case (st_q)
            CGP_ST_IDLE: begin
                if (trig) begin
                    st_d = CGP_ST_HIGH;
                    cnt_d = len;
                end
            end
            CGP_ST_HIGH: begin
                if (last) begin
                    st_d = (repeat_en && !stop_q) ? CGP_ST_LOW : CGP_ST_IDLE;
                    cnt_d = len;
                end
            end
            CGP_ST_LOW: begin
                if (stop_q || !repeat_en) begin
                    st_d = CGP_ST_IDLE;
                end else if (last) begin
                    st_d = CGP_ST_HIGH;
                    cnt_d = len;
                end
            end
            default: begin
                st_d = CGP_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= CGP_ST_IDLE;
            cnt_q <= '0;
            out_q <= 1'b0;
            stop_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            out_q <= (st_d == CGP_ST_HIGH);
            if (trig) begin
                stop_q <= 1'b0;
            end else if (flags_read) begin
                stop_q <= 1'b1;
            end
        end
    end

    assign pulse = out_q;
endmodule : cgp_pulse_gen

// ==== logic/cgp_sync3.sv ====
// Three-stage synchroniser for a pin input.
// Output changes only once the second and third stages agree.
`timescale 1ns/1ps
module cgp_sync3 (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic din,
    output logic dout
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic out_q;
    wire agree = (s2_q == s3_q);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (agree) begin
                out_q <= s3_q;
            end
        end
    end

    assign dout = out_q;
endmodule : cgp_sync3

// ==== verif/cgp_pin_ctrl_sva.sv ====
// Checker for the second-pin and bus-pin block, on top-level ports only.
// Assumes interrupt sources stay low while the pin function changes.
`timescale 1ns/1ps
module cgp_pin_ctrl_sva #(
    parameter int PULSE_CYC = 8,
    parameter int JACK_PULSE_CYC = 6
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Sources and pins
    input wire logic irq_short,
    input wire logic spi_select,
    input wire logic pin2_o,
    input wire logic pin2_oe,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic scl_o,
    input wire logic scl_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] ctl_q;
    logic [31:0] hi_q;
    wire ctl_wr = reg_wr && reg_addr == 7'h63;
    // Undriven pin values are meaningless, so only a driven high counts
    wire drv = pin2_o && pin2_oe;
    always_ff @(posedge clk) begin
        ctl_q <= !rst_n ? 8'h00 : (ctl_wr ? reg_wdata : ctl_q);
        hi_q <= (!rst_n || !drv) ? 32'h0 : hi_q + 32'h1;
    end
    sequence s_trig;
        $rose(irq_short) && ctl_q[7:4] == 4'hc && !ctl_q[1] && !drv;
    endsequence
    a_gp_out_level: assert property (
        ctl_wr && reg_wdata[7:4] == 4'h4 |=> pin2_oe && pin2_o == $past(reg_wdata[3]))
        else $error("pin level differs from output bit");
    a_off_undriven: assert property (
        ctl_wr && reg_wdata[7:4] inside {4'h0, 4'h1, 4'h3, 4'h5, 4'h6, 4'h7, 4'hd}
        |=> !pin2_oe) else $error("pin driven in a non-output function");
    a_bit0_zero: assert property (
        reg_rd && reg_addr == 7'h63 |=> !reg_rdata[0]) else $error("reserved bit read as one");
    a_bus_never_high: assert property (
        !sda_o && !scl_o) else $error("bus pin driven high");
    a_i2c_no_bus: assert property (
        !spi_select [*6] |-> !sda_oe && !scl_oe) else $error("bus pin pulled outside spi mode");
    a_irq_rise: assert property (
        s_trig |=> drv) else $error("interrupt pulse did not start");
    a_pulse_len: assert property (
        $fell(drv) && !ctl_q[1] && ctl_q[7:4] inside {4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf}
        |-> hi_q == PULSE_CYC) else $error("interrupt pulse length wrong");
    a_jack_len: assert property (
        $fell(drv) && ctl_q[7:4] == 4'h2 |-> hi_q == JACK_PULSE_CYC)
        else $error("jack pulse length wrong");
endmodule : cgp_pin_ctrl_sva
bind cgp_pin_ctrl cgp_pin_ctrl_sva #(.PULSE_CYC(PULSE_CYC), .JACK_PULSE_CYC(JACK_PULSE_CYC))
    sva_i (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .irq_short,
    .spi_select, .pin2_o, .pin2_oe, .sda_o, .sda_oe, .scl_o, .scl_oe);

// ==== verif/cgp_pin_peer.sv ====
// Far side of the pins: bus pull-ups and a peripheral on the second pin.
// Assumes the peripheral drives the second pin whenever the block does not.
`timescale 1ns/1ps
module cgp_pin_peer (
    // From the block
    input wire logic pin2_o,
    input wire logic pin2_oe,
    input wire logic sda_oe,
    input wire logic scl_oe,
    // Peripheral controls
    input wire logic ext_pin2,
    input wire logic ext_sda_low,
    input wire logic ext_scl_low,
    // Resolved levels
    output logic pin2_lvl,
    output logic sda_lvl,
    output logic scl_lvl
);
    // Pull-up wins unless either party pulls low
    assign sda_lvl = !(sda_oe || ext_sda_low);
    assign scl_lvl = !(scl_oe || ext_scl_low);
    assign pin2_lvl = pin2_oe ? pin2_o : ext_pin2;
endmodule : cgp_pin_peer

// ==== verif/test_codec_gpio_pin_control.sv ====
// Self-checking bench for the second-pin and bus-pin block.
// Assumes shortened pulse lengths; inputs change on the falling edge.
`timescale 1ns/1ps
module test_codec_gpio_pin_control;
    localparam int PW = 8;
    localparam int JW = 6;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [6:0] reg_addr = 7'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [3:0] irq = 4'h0;
    logic flags_read = 1'b0;
    logic spi_select = 1'b0;
    logic ext_pin2 = 1'b0;
    logic ext_sda_low = 1'b0;
    logic ext_scl_low = 1'b0;
    logic bclk_out = 1'b0;
    logic bclk_master = 1'b0;
    logic dmic_clk = 1'b0;
    logic bclk_in, dmic_rise_data, dmic_fall_data;
    logic [7:0] reg_rdata;
    logic reg_hit, pin2_o, pin2_oe, pin2_lvl, dmic_en;
    logic sda_o, sda_oe, sda_lvl, scl_o, scl_oe, scl_lvl;
    int n_fail = 0;
    int check_count = 0;
    always #5 clk = ~clk;
    cgp_pin_ctrl #(.PULSE_CYC(PW), .JACK_PULSE_CYC(JW)) cgp_pin_ctrl_i (
        .clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_hit,
        .irq_headset(irq[3]), .irq_button(irq[2]), .irq_short(irq[1]), .irq_agc_noise(irq[0]),
        .flags_read, .spi_select, .pin2_i(pin2_lvl), .pin2_o, .pin2_oe, .bclk_out,
        .bclk_master, .bclk_in, .dmic_clk, .dmic_rise_data, .dmic_fall_data,
        .dmic_en, .sda_i(sda_lvl), .sda_o, .sda_oe, .scl_i(scl_lvl), .scl_o, .scl_oe);
    cgp_pin_peer cgp_pin_peer_i (.pin2_o, .pin2_oe, .sda_oe, .scl_oe, .ext_pin2,
        .ext_sda_low, .ext_scl_low, .pin2_lvl, .sda_lvl, .scl_lvl);
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // Trailing idle cycle keeps back-to-back strobes from toggling in one step
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
        cyc(1);
    endtask : wr
    task automatic rdc(input logic [6:0] a, input logic [7:0] exp, input string what);
        reg_addr = a;
        reg_rd = 1'b1;
        cyc(1);
        reg_rd = 1'b0;
        chk(what, exp, reg_rdata);
        cyc(1);
    endtask : rdc
    function automatic logic [3:0] srcs(input logic [3:0] code);
        case (code)
            4'h2: srcs = 4'b1000;
            4'h9: srcs = 4'b1100;
            4'ha: srcs = 4'b1111;
            4'hb: srcs = 4'b0011;
            4'hc, 4'he: srcs = 4'b0010;
            4'hf: srcs = 4'b0100;
            default: srcs = 4'b0000;
        endcase
    endfunction : srcs
    task automatic t_regs();
        rdc(7'h63, 8'h00, "pin ctrl reset");
        rdc(7'h64, 8'h00, "bus ctrl reset");
        wr(7'h65, 8'hff);
        rdc(7'h65, 8'h00, "unmapped read");
        chk("unmapped hit", 8'h00, {7'h0, reg_hit});
        rdc(7'h63, 8'h00, "pin ctrl kept");
        chk("mapped hit", 8'h01, {7'h0, reg_hit});
    endtask : t_regs
    task automatic t_gp();
        wr(7'h63, 8'h48);
        chk("pin2 high", 8'h01, {7'h0, pin2_lvl});
        wr(7'h63, 8'h40);
        chk("pin2 low", 8'h00, {7'h0, pin2_lvl});
        ext_pin2 = 1'b1;
        wr(7'h63, 8'h30);
        cyc(8);
        rdc(7'h63, 8'h34, "pin2 input high");
        ext_pin2 = 1'b0;
        cyc(8);
        rdc(7'h63, 8'h30, "pin2 input low");
        for (int c = 5; c < 9; c++) begin
            wr(7'h63, {c[3:0], 4'h0});
            chk("mic enable", {7'h0, c < 8}, {7'h0, dmic_en});
        end
        wr(7'h63, 8'h00);
    endtask : t_gp
    // Data moves apart from the mic clock so each edge sees settled data
    task automatic mic_step(input logic d, input logic c, input logic [1:0] exp);
        ext_pin2 = d;
        cyc(8);
        dmic_clk = c;
        cyc(8);
        chk("mic samples", {6'h0, exp}, {6'h0, dmic_rise_data, dmic_fall_data});
    endtask : mic_step
    task automatic t_mic();
        wr(7'h63, 8'h50);
        mic_step(1'b1, 1'b1, 2'b10);
        mic_step(1'b1, 1'b0, 2'b11);
        mic_step(1'b0, 1'b1, 2'b01);
        mic_step(1'b0, 1'b0, 2'b00);
        wr(7'h63, 8'h00);
    endtask : t_mic
    task automatic t_bclk();
        wr(7'h63, 8'h80);
        bclk_master = 1'b1;
        bclk_out = 1'b1;
        cyc(1);
        chk("bclk driven high", 8'h01, {7'h0, pin2_lvl});
        bclk_out = 1'b0;
        cyc(1);
        chk("bclk driven low", 8'h00, {7'h0, pin2_lvl});
        bclk_master = 1'b0;
        ext_pin2 = 1'b1;
        cyc(8);
        chk("bclk input", 8'h01, {7'h0, bclk_in});
        wr(7'h63, 8'h00);
        cyc(8);
        chk("bclk input gated", 8'h00, {7'h0, bclk_in});
        ext_pin2 = 1'b0;
    endtask : t_bclk
    task automatic t_irq();
        logic [3:0] codes [8] = '{4'h2, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
        logic [3:0] m;
        foreach (codes[k]) begin
            m = srcs(codes[k]);
            wr(7'h63, {codes[k], 4'h0});
            for (int s = 0; s < 4; s++) begin
                irq[s] = 1'b1;
                cyc(1);
                irq[s] = 1'b0;
                cyc(1);
                chk("irq pin", {7'h0, m[s]}, {7'h0, pin2_lvl});
                cyc(PW + 2);
                chk("irq pin after", 8'h00, {7'h0, pin2_lvl});
            end
        end
    endtask : t_irq
    task automatic t_repeat();
        wr(7'h63, 8'hc2);
        irq[1] = 1'b1;
        cyc(1);
        irq[1] = 1'b0;
        cyc(PW + 1);
        chk("repeat low", 8'h00, {7'h0, pin2_lvl});
        cyc(PW);
        chk("repeat high", 8'h01, {7'h0, pin2_lvl});
        flags_read = 1'b1;
        cyc(1);
        flags_read = 1'b0;
        cyc(4 * PW);
        chk("repeat stopped", 8'h00, {7'h0, pin2_lvl});
        wr(7'h63, 8'h00);
    endtask : t_repeat
    task automatic t_bus();
        wr(7'h64, 8'h88);
        cyc(6);
        chk("bus in i2c mode", 8'h03, {6'h0, sda_lvl, scl_lvl});
        spi_select = 1'b1;
        cyc(6);
        chk("bus pulled low", 8'h00, {6'h0, sda_lvl, scl_lvl});
        wr(7'h64, 8'ha8);
        chk("sda released", 8'h02, {6'h0, sda_lvl, scl_lvl});
        wr(7'h64, 8'h8a);
        chk("scl released", 8'h01, {6'h0, sda_lvl, scl_lvl});
        ext_sda_low = 1'b1;
        wr(7'h64, 8'h44);
        cyc(8);
        rdc(7'h64, 8'h45, "bus inputs");
        ext_sda_low = 1'b0;
        ext_scl_low = 1'b1;
        cyc(8);
        rdc(7'h64, 8'h54, "bus inputs swapped");
        ext_scl_low = 1'b0;
        wr(7'h64, 8'h22);
        chk("bus mode off", 8'h03, {6'h0, sda_lvl, scl_lvl});
    endtask : t_bus
    task automatic wrap_up();
        if (n_fail == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        cyc(16);
        rst_n = 1'b1;
        t_regs();
        t_gp();
        t_mic();
        t_bclk();
        t_irq();
        t_repeat();
        t_bus();
        wrap_up();
    end
    // Whole run is about 650 cycles; this leaves ample margin
    initial begin
        #50000;
        n_fail++;
        wrap_up();
    end
endmodule : test_codec_gpio_pin_control
